// [rtl/mces_defs.svh]
// Event codes, field positions, widths and register offsets of the credit event selector.
`ifndef MCES_DEFS_SVH
`define MCES_DEFS_SVH
`define MCES_EV_A0_ADDR_ACQ_LOW 8'h80
`define MCES_EV_A0_ADDR_ACQ_HIGH 8'h81
`define MCES_EV_A0_ADDR_USE_LOW 8'h82
`define MCES_EV_A0_ADDR_USE_HIGH 8'h83
`define MCES_EV_A1_ADDR_ACQ_LOW 8'h84
`define MCES_EV_A1_ADDR_ACQ_HIGH 8'h85
`define MCES_EV_A1_ADDR_USE_LOW 8'h86
`define MCES_EV_A0_BLK_ACQ_LOW 8'h88
`define MCES_EV_A0_BLK_ACQ_HIGH 8'h89
`define MCES_EV_A0_BLK_USE_LOW 8'h8a
`define MCES_EV_A0_BLK_USE_HIGH 8'h8b
`define MCES_CTL_EVENT_LSB 0
`define MCES_CTL_EVENT_MSB 7
`define MCES_CTL_UMASK_LSB 8
`define MCES_CTL_UMASK_MSB 15
`define MCES_CTL_ENABLE_BIT 22
`define MCES_OFF_CTL 4'h0
`define MCES_OFF_CNT_LO 4'h4
`define MCES_OFF_CNT_HI 4'h8
`define MCES_OFF_STATUS 4'hc
`define MCES_CTL_RESET 32'h0000_0000
`endif

// [rtl/mces_pkg.sv]
// Types shared by the credit event selector.
package mces_pkg;
    typedef enum logic [1:0] {
        MCES_SRC_A0_ADDR = 2'b00,
        MCES_SRC_A0_BLK = 2'b01,
        MCES_SRC_A1_ADDR = 2'b11,
        MCES_SRC_NONE = 2'b10
    } mces_src_e;
endpackage : mces_pkg

// [rtl/mces_decode.sv]
// Decoder of event code into credit source, measure and port half.
`timescale 1ns/1ps
`include "mces_defs.svh"
module mces_decode
    import mces_pkg::*;
(
    // Event selection.
    input wire logic [7:0] event_code,
    // Decoded selection.
    output mces_src_e src,
    output logic is_use,
    output logic is_high,
    output logic known
);
    // Each supported code names a source, a measure and a port half.
    always_comb begin
        src = MCES_SRC_NONE;
        is_use = 1'b0;
        is_high = 1'b0;
        known = 1'b1;
        unique case (event_code)
            `MCES_EV_A0_ADDR_ACQ_LOW: src = MCES_SRC_A0_ADDR; // R1
            `MCES_EV_A0_ADDR_ACQ_HIGH: begin // R1
                src = MCES_SRC_A0_ADDR;
                is_high = 1'b1;
            end
            `MCES_EV_A0_ADDR_USE_LOW: begin // R2
                src = MCES_SRC_A0_ADDR;
                is_use = 1'b1;
            end
            `MCES_EV_A0_ADDR_USE_HIGH: begin // R2
                src = MCES_SRC_A0_ADDR;
                is_use = 1'b1;
                is_high = 1'b1;
            end
            `MCES_EV_A0_BLK_ACQ_LOW: src = MCES_SRC_A0_BLK; // R3
            `MCES_EV_A0_BLK_ACQ_HIGH: begin // R3
                src = MCES_SRC_A0_BLK;
                is_high = 1'b1;
            end
            `MCES_EV_A0_BLK_USE_LOW: begin // R4
                src = MCES_SRC_A0_BLK;
                is_use = 1'b1;
            end
            `MCES_EV_A0_BLK_USE_HIGH: begin // R4
                src = MCES_SRC_A0_BLK;
                is_use = 1'b1;
                is_high = 1'b1;
            end
            `MCES_EV_A1_ADDR_ACQ_LOW: src = MCES_SRC_A1_ADDR; // R5
            `MCES_EV_A1_ADDR_ACQ_HIGH: begin // R5
                src = MCES_SRC_A1_ADDR;
                is_high = 1'b1;
            end
            `MCES_EV_A1_ADDR_USE_LOW: begin // R6
                src = MCES_SRC_A1_ADDR;
                is_use = 1'b1;
            end
            default: known = 1'b0;
        endcase
    end
endmodule : mces_decode

// [rtl/mces_combine.sv]
// Per-port mask and OR or sum reduction of one cycle of credit activity.
`timescale 1ns/1ps
module mces_combine #(
    parameter int PORTS = 8,
    parameter int OCC_W = 6,
    parameter int SUM_W = 9
) (
    // Per-port inputs.
    input wire logic [PORTS-1:0] port_en,
    input wire logic [PORTS-1:0] acq,
    input wire logic [PORTS*OCC_W-1:0] occ,
    // Reductions.
    output logic acq_any,
    output logic [SUM_W-1:0] occ_sum
);
    logic [PORTS-1:0] acq_m;
    logic [SUM_W-1:0] part [PORTS];
    // Mask bit n gates port n only.
    for (genvar n = 0; n < PORTS; n++) begin : g_port
        assign acq_m[n] = acq[n] & port_en[n]; // R7
        assign part[n] = port_en[n] ? SUM_W'(occ[n*OCC_W +: OCC_W]) : '0; // R7
    end
    // Acquired events count a cycle once for any enabled port.
    assign acq_any = |acq_m; // R9
    // Occupancy events add all enabled ports.
    always_comb begin
        occ_sum = '0;
        for (int n = 0; n < PORTS; n++) begin
            occ_sum = occ_sum + part[n]; // R10
        end
    end
endmodule : mces_combine

// [rtl/mces_top.sv]
// Credit event selector and counter of one mesh stop performance monitor.
`timescale 1ns/1ps
`include "mces_defs.svh"
// Behaviour
// R1 - 0x80/0x81: agent0 address credits acquired
// R2 - 0x82/0x83: agent0 address credits in use
// R3 - 0x88/0x89: agent0 block credits acquired
// R4 - 0x8a/0x8b: agent0 block credits in use
// R5 - 0x84/0x85: agent1 address credits acquired
// R6 - 0x86: agent1 address credits in use
// R7 - Mask bit n enables low port n
// R8 - Mask bits 0..2 enable ports 8..10
// R9 - Acquired events count OR of ports
// R10 - Occupancy events count sum of ports
// R11 - Ports 8..10 unused, contribute zero
// R12 - Counter adds contribution each valid cycle
module mces_top
    import mces_pkg::*;
#(
    parameter int OCC_W = 6,
    parameter int CNT_W = 48
) (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst,
    // Register port.
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Agent0 address channel credits, per low transgress port.
    input wire logic [7:0] agent0_addr_credit_acq,
    input wire logic [8*OCC_W-1:0] agent0_addr_credit_use,
    // Agent0 block data channel credits.
    input wire logic [7:0] agent0_blk_credit_acq,
    input wire logic [8*OCC_W-1:0] agent0_blk_credit_use,
    // Agent1 address channel credits.
    input wire logic [7:0] agent1_addr_credit_acq,
    input wire logic [8*OCC_W-1:0] agent1_addr_credit_use,
    // Counter value.
    output logic [CNT_W-1:0] count
);
    localparam int SUM_W = OCC_W + 3;
    logic [31:0] ctl_reg;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic [31:0] rdata_reg;
    mces_src_e src;
    logic is_use;
    logic is_high;
    logic known;
    logic [7:0] sel_acq;
    logic [8*OCC_W-1:0] sel_use;
    logic [7:0] port_en;
    logic acq_any;
    logic [SUM_W-1:0] occ_sum;
    logic [SUM_W-1:0] contrib;
    logic ev_valid;

    // Turns the event code into source, measure and half.
    mces_decode u_decode (
        .event_code(ctl_reg[`MCES_CTL_EVENT_MSB:`MCES_CTL_EVENT_LSB]),
        .src(src),
        .is_use(is_use),
        .is_high(is_high),
        .known(known)
    );

    // Routes the chosen credit source to the reduction.
    always_comb begin
        unique case (src)
            MCES_SRC_A0_ADDR: begin
                sel_acq = agent0_addr_credit_acq;
                sel_use = agent0_addr_credit_use;
            end
            MCES_SRC_A0_BLK: begin
                sel_acq = agent0_blk_credit_acq;
                sel_use = agent0_blk_credit_use;
            end
            MCES_SRC_A1_ADDR: begin
                sel_acq = agent1_addr_credit_acq;
                sel_use = agent1_addr_credit_use;
            end
            default: begin
                sel_acq = '0;
                sel_use = '0;
            end
        endcase
    end

    // High-half codes map mask bits 0..2 to ports 8..10, which carry no
    // credits here, so their mask enables no low port at all.
    assign port_en = is_high ? 8'h00 : ctl_reg[`MCES_CTL_UMASK_MSB:`MCES_CTL_UMASK_LSB]; // R8 R11

    // Masks and reduces the chosen ports.
    mces_combine #(
        .PORTS(8),
        .OCC_W(OCC_W),
        .SUM_W(SUM_W)
    ) u_combine (
        .port_en(port_en),
        .acq(sel_acq),
        .occ(sel_use),
        .acq_any(acq_any),
        .occ_sum(occ_sum)
    );

    // Picks the OR bit or the sum as this cycle's increment.
    assign contrib = is_use ? occ_sum : SUM_W'(acq_any); // R9 R10
    assign ev_valid = known & ctl_reg[`MCES_CTL_ENABLE_BIT];
    assign cnt_next = cnt_reg + CNT_W'(contrib);

    // Control register holds event code, unit mask and enable.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ctl_reg <= `MCES_CTL_RESET;
        end else if (reg_wr && reg_addr == `MCES_OFF_CTL) begin
            ctl_reg <= reg_wdata;
        end
    end

    // Counter adds the increment each valid cycle; software may preload it.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cnt_reg <= '0; // R12
        end else if (reg_wr && reg_addr == `MCES_OFF_CNT_LO) begin
            cnt_reg <= {cnt_reg[CNT_W-1:32], reg_wdata};
        end else if (reg_wr && reg_addr == `MCES_OFF_CNT_HI) begin
            cnt_reg <= {reg_wdata[CNT_W-33:0], cnt_reg[31:0]};
        end else if (ev_valid) begin
            cnt_reg <= cnt_next; // R12
        end
    end

    // Read data stand one cycle after the read strobe only.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rdata_reg <= '0;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `MCES_OFF_CTL: rdata_reg <= ctl_reg;
                `MCES_OFF_CNT_LO: rdata_reg <= cnt_reg[31:0];
                `MCES_OFF_CNT_HI: rdata_reg <= 32'(cnt_reg[CNT_W-1:32]);
                `MCES_OFF_STATUS: rdata_reg <= {29'h0, is_use, is_high, known};
                default: rdata_reg <= '0;
            endcase
        end else begin
            rdata_reg <= '0;
        end
    end

    assign reg_rdata = rdata_reg;
    assign count = cnt_reg;
endmodule : mces_top

// [dv/mces_monitor.sv]
// Checker of event counting and register reads of the credit event selector.
`timescale 1ns/1ps
module mces_monitor #(
    parameter int OCC_W = 6,
    parameter int CNT_W = 48
) (
    // Clock, reset and register port.
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    // Credit activity and counter.
    input wire logic [7:0] agent0_addr_credit_acq,
    input wire logic [8*OCC_W-1:0] agent0_addr_credit_use,
    input wire logic [7:0] agent0_blk_credit_acq,
    input wire logic [8*OCC_W-1:0] agent0_blk_credit_use,
    input wire logic [7:0] agent1_addr_credit_acq,
    input wire logic [8*OCC_W-1:0] agent1_addr_credit_use,
    input wire logic [CNT_W-1:0] count
);
    logic [7:0] ev, um, a;
    logic en, hit;
    logic [8*OCC_W-1:0] u;
    logic [15:0] s;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // Shadow of the control word, live from the cycle after its write.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            {en, um, ev} <= '0;
        end else if (reg_wr && reg_addr == 4'h0) begin
            {en, um, ev} <= {reg_wdata[22], reg_wdata[15:0]};
        end
    end
    // Selected source, masked OR and masked occupancy sum.
    always_comb begin
        a = ev[3] ? agent0_blk_credit_acq : (ev[2] ? agent1_addr_credit_acq : agent0_addr_credit_acq);
        u = ev[3] ? agent0_blk_credit_use : (ev[2] ? agent1_addr_credit_use : agent0_addr_credit_use);
        hit = |(a & um);
        s = '0;
        for (int i = 0; i < 8; i++) begin
            if (um[i]) s = s + 16'(u[i*OCC_W+:OCC_W]);
        end
    end
    sequence run_s;
        en && !reg_wr;
    endsequence
    acq_or_a: assert property (run_s ##0 ev inside {8'h80, 8'h84, 8'h88} |=>
        count == $past(count) + CNT_W'($past(hit))) else $error("acquire count off");
    use_sum_a: assert property (run_s ##0 ev inside {8'h82, 8'h86, 8'h8a} |=>
        count == $past(count) + CNT_W'($past(s))) else $error("occupancy sum off");
    high_zero_a: assert property (run_s ##0 ev[0] |=> $stable(count))
        else $error("high half code counted");
    idle_hold_a: assert property (!en && !reg_wr |=> $stable(count))
        else $error("disabled counter moved");
    rd_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000)
        else $error("read data outside read slot");
    rd_low_a: assert property (reg_rd && reg_addr == 4'h4 |=> reg_rdata == $past(count[31:0]))
        else $error("low count read off");
    rd_high_a: assert property (reg_rd && reg_addr == 4'h8 |=>
        reg_rdata[15:0] == $past(count[47:32])) else $error("high count read off");
    rd_ctl_a: assert property (reg_rd && reg_addr == 4'h0 |=> reg_rdata[15:0] == {um, ev})
        else $error("control read off");
endmodule : mces_monitor
bind mces_top mces_monitor #(.OCC_W(OCC_W), .CNT_W(CNT_W)) mces_monitor_inst (.*);

// [dv/mces_credit_src.sv]
// Model of the mesh stop credit tracking that feeds the selector.
`timescale 1ns/1ps
module mces_credit_src (
    // Clock.
    input wire logic core_clk,
    // Credit activity per low transgress port.
    output logic [7:0] agent0_addr_credit_acq,
    output logic [47:0] agent0_addr_credit_use,
    output logic [7:0] agent0_blk_credit_acq,
    output logic [47:0] agent0_blk_credit_use,
    output logic [7:0] agent1_addr_credit_acq,
    output logic [47:0] agent1_addr_credit_use
);
    int seed = 32'h7675;
    // Quiet ports until the first edge.
    initial begin
        {agent0_addr_credit_acq, agent0_blk_credit_acq, agent1_addr_credit_acq} = '0;
        {agent0_addr_credit_use, agent0_blk_credit_use, agent1_addr_credit_use} = '0;
    end
    // Sparse acquisitions and random occupancy, renewed after each edge.
    always @(posedge core_clk) begin
        agent0_addr_credit_acq <= 8'($random(seed) & $random(seed));
        agent0_blk_credit_acq <= 8'($random(seed) & $random(seed));
        agent1_addr_credit_acq <= 8'($random(seed) & $random(seed));
        agent0_addr_credit_use <= 48'({$random(seed), $random(seed)});
        agent0_blk_credit_use <= 48'({$random(seed), $random(seed)});
        agent1_addr_credit_use <= 48'({$random(seed), $random(seed)});
    end
endmodule : mces_credit_src

// [dv/tb.sv]
// Self-checking testbench of the credit event selector.
`timescale 1ns/1ps
module tb;
    logic core_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, rd_q = 0, en_m = 0;
    logic [3:0] reg_addr = 0;
    logic [31:0] reg_wdata = 0, reg_rdata;
    logic [31:0] q[$];
    logic [7:0] agent0_addr_credit_acq, agent0_blk_credit_acq, agent1_addr_credit_acq;
    logic [47:0] agent0_addr_credit_use, agent0_blk_credit_use, agent1_addr_credit_use;
    logic [47:0] count, u, exp_cnt = 0;
    logic [7:0] ev_m = 0, um_m = 0, a, ev, mk;
    logic [15:0] inc;
    logic [7:0] codes [12] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'h88,
        8'h89, 8'h8a, 8'h8b, 8'h87};
    int miscompares = 0, checks = 0, seed = 32'h7675;
    mces_top mces_top_inst (.*);
    mces_credit_src mces_credit_src_inst (.*);
    initial forever #4 core_clk = ~core_clk;
    // Expected per-cycle increment from the shadow control word.
    always_comb begin
        a = ev_m[3] ? agent0_blk_credit_acq : (ev_m[2] ? agent1_addr_credit_acq : agent0_addr_credit_acq);
        u = ev_m[3] ? agent0_blk_credit_use : (ev_m[2] ? agent1_addr_credit_use : agent0_addr_credit_use);
        inc = 16'(|(a & um_m));
        if (ev_m[1]) begin
            inc = 0;
            for (int i = 0; i < 8; i++) if (um_m[i]) inc = inc + 16'(u[i*6+:6]);
        end
        if (!(ev_m inside {8'h80, 8'h82, 8'h84, 8'h86, 8'h88, 8'h8a})) inc = 0;
    end
    // Expected counter and control shadow; counts are only written while disabled.
    always @(posedge core_clk) begin
        if (reg_wr && reg_addr == 4'h4) exp_cnt[31:0] <= reg_wdata;
        else if (reg_wr && reg_addr == 4'h8) exp_cnt[47:32] <= reg_wdata[15:0];
        else if (en_m) exp_cnt <= exp_cnt + 48'(inc);
        if (reg_wr && reg_addr == 4'h0) {en_m, um_m, ev_m} <= {reg_wdata[22], reg_wdata[15:0]};
        rd_q <= reg_rd;
    end
    // Oldest noted read value against each returned word.
    always @(negedge core_clk) if (rd_q) cmp(q.pop_front());
    task cmp(input logic [31:0] e);
        checks++;
        if (reg_rdata !== e) begin
            miscompares++;
            $display("unexpected reg_rdata expected %h seen %h", e, reg_rdata);
        end
    endtask : cmp
    // One register cycle; a read notes its expected data.
    task bus(input logic w, input logic [3:0] ad, input logic [31:0] d);
        reg_wr <= w;
        reg_rd <= !w;
        reg_addr <= ad;
        reg_wdata <= d;
        if (!w) q.push_back(d);
        @(posedge core_clk);
        {reg_wr, reg_rd} <= 2'b00;
        @(posedge core_clk);
    endtask : bus
    task results;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : results
    // Watchdog against a hung run.
    initial begin
        #100000;
        miscompares++;
        results();
    end
    // Every code with single-bit masks, then with random masks.
    initial begin
        repeat (8) @(posedge core_clk);
        rst <= 0;
        @(posedge core_clk);
        bus(0, 4'h4, 0);
        bus(0, 4'h6, 0);
        for (int k = 0; k < 24; k++) begin
            ev = codes[k % 12];
            mk = k < 12 ? 8'h01 << (k % 8) : 8'($random(seed));
            bus(1, 4'h4, 0);
            bus(1, 4'h8, 0);
            bus(1, 4'h0, {9'h000, 1'b1, 6'h00, mk, ev});
            repeat (20) @(posedge core_clk);
            bus(1, 4'h0, {16'h0000, mk, ev});
            bus(0, 4'h4, exp_cnt[31:0]);
            bus(0, 4'h8, {16'h0000, exp_cnt[47:32]});
            bus(0, 4'h0, {16'h0000, mk, ev});
            bus(0, 4'hc, {29'h0, ev != 8'h87 && ev[1], ev != 8'h87 && ev[0], ev != 8'h87});
        end
        results();
    end
endmodule : tb
